// File: registered_bus_transceiver.sv
// top of the 16-bit registered bus transceiver with status port
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
module registered_bus_transceiver #(
  parameter int SECTIONS = xcvr_pkg::SECTIONS,
  parameter int SECTION_W = xcvr_pkg::SECTION_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [SECTIONS-1:0] output_enable_n,
  input wire logic [SECTIONS-1:0] port_drive_side,
  input wire logic [SECTIONS-1:0] a_capture_clock,
  input wire logic [SECTIONS-1:0] b_capture_clock,
  input wire logic [SECTIONS-1:0] a_port_source_select,
  input wire logic [SECTIONS-1:0] b_port_source_select,
  input wire logic [SECTIONS*SECTION_W-1:0] a_port_data_in,
  output logic [SECTIONS*SECTION_W-1:0] a_port_data_out,
  output logic [SECTIONS*SECTION_W-1:0] a_port_data_oe,
  input wire logic [SECTIONS*SECTION_W-1:0] b_port_data_in,
  output logic [SECTIONS*SECTION_W-1:0] b_port_data_out,
  output logic [SECTIONS*SECTION_W-1:0] b_port_data_oe,
  input wire logic [xcvr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [xcvr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [xcvr_pkg::DATA_W-1:0] reg_rdata
);
  import xcvr_pkg::*;

  localparam int BW = SECTIONS * SECTION_W;

  logic [SECTIONS-1:0] a_rise;
  logic [SECTIONS-1:0] b_rise;
  logic [BW-1:0] a_store;
  logic [BW-1:0] b_store;
  logic [SECTIONS-1:0] a_driven;
  logic [SECTIONS-1:0] b_driven;
  logic [SECTIONS-1:0] a_captured;
  logic [SECTIONS-1:0] b_captured;
  logic [DATA_W-1:0] next_rdata;

  // places a narrow field into a zeroed bus word
  function automatic logic [DATA_W-1:0] widen(input logic [BW-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BW-1:0] = v;
    return w;
  endfunction

  // ==========================================================
  // sections
  // each section has its own controls and storage
  for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
    localparam int LO = s * SECTION_W;

    rise_detect u_a_rise (
      .ref_clk(ref_clk),
      .rst(rst),
      .level(a_capture_clock[s]),
      .rise(a_rise[s])
    );

    rise_detect u_b_rise (
      .ref_clk(ref_clk),
      .rst(rst),
      .level(b_capture_clock[s]),
      .rise(b_rise[s])
    );

    // storage ignores enable and direction entirely, so isolation
    // and transceiver modes still capture
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        a_store[LO +: SECTION_W] <= RST_STORED;
      end else if (a_rise[s]) begin
        a_store[LO +: SECTION_W] <= a_port_data_in[LO +: SECTION_W];
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        b_store[LO +: SECTION_W] <= RST_STORED;
      end else if (b_rise[s]) begin
        b_store[LO +: SECTION_W] <= b_port_data_in[LO +: SECTION_W];
      end
    end

    // during a capture edge the opposite port keeps its normal
    // decode; its level then is unspecified
    port_steer #(
      .W(SECTION_W)
    ) u_steer (
      .rst(rst),
      .output_enable_n(output_enable_n[s]),
      .port_drive_side(port_drive_side[s]),
      .a_port_source_select(a_port_source_select[s]),
      .b_port_source_select(b_port_source_select[s]),
      .a_live(a_port_data_in[LO +: SECTION_W]),
      .b_live(b_port_data_in[LO +: SECTION_W]),
      .a_stored(a_store[LO +: SECTION_W]),
      .b_stored(b_store[LO +: SECTION_W]),
      .a_out(a_port_data_out[LO +: SECTION_W]),
      .a_oe(a_port_data_oe[LO +: SECTION_W]),
      .b_out(b_port_data_out[LO +: SECTION_W]),
      .b_oe(b_port_data_oe[LO +: SECTION_W]),
      .a_driven(a_driven[s]),
      .b_driven(b_driven[s])
    );
  end

  // ==========================================================
  // sticky capture flags, write one to clear; a capture in the
  // clearing cycle wins so no edge is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_captured <= '0;
    end else begin
      a_captured <= a_rise | (a_captured & ~(
        (reg_write && reg_addr == OFS_CAPTURE_FLAGS) ?
        reg_wdata[POS_A_CAPTURED +: SECTIONS] : '0));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      b_captured <= '0;
    end else begin
      b_captured <= b_rise | (b_captured & ~(
        (reg_write && reg_addr == OFS_CAPTURE_FLAGS) ?
        reg_wdata[POS_B_CAPTURED +: SECTIONS] : '0));
    end
  end

  // ==========================================================
  // register read port; unmapped addresses read zero
  always_comb begin
    next_rdata = RST_RDATA;
    if (reg_read) begin
      case (reg_addr)
        OFS_STORED_A: begin
          next_rdata = widen(a_store);
        end
        OFS_STORED_B: begin
          next_rdata = widen(b_store);
        end
        OFS_DRIVE_STATUS: begin
          next_rdata[POS_A_DRIVEN +: SECTIONS] = a_driven;
          next_rdata[POS_B_DRIVEN +: SECTIONS] = b_driven;
        end
        OFS_CAPTURE_FLAGS: begin
          next_rdata[POS_A_CAPTURED +: SECTIONS] = a_captured;
          next_rdata[POS_B_CAPTURED +: SECTIONS] = b_captured;
        end
        default: begin
          next_rdata = RST_RDATA;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RST_RDATA;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// File: xcvr_pkg.sv
// constants shared by the registered bus transceiver and its helpers
package xcvr_pkg;
  // ==========================================================
  // structure
  localparam int SECTIONS = 2;
  localparam int SECTION_W = 8;
  localparam int BUS_W = SECTIONS * SECTION_W;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] OFS_STORED_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STORED_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DRIVE_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_FLAGS = 8'h0C;

  // ==========================================================
  // field positions in status and flag words
  localparam int POS_A_DRIVEN = 0;
  localparam int POS_B_DRIVEN = 2;
  localparam int POS_A_CAPTURED = 0;
  localparam int POS_B_CAPTURED = 2;

  // ==========================================================
  // reset values
  localparam logic [SECTION_W-1:0] RST_STORED = 8'h00;
  localparam logic RST_CLOCK_LEVEL = 1'b1;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // drive decode result for one section
  typedef enum {DRIVE_NONE, DRIVE_A, DRIVE_B} drive_t;
endpackage

// File: rise_detect.sv
// rising edge detector for a capture clock sampled on ref_clk
`timescale 1ns/1ns
module rise_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic level,
  output logic rise
);
  import xcvr_pkg::*;

  logic prev;

  // ==========================================================
  // previous level; resets high so a pin already high at release
  // is not taken for a fresh edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev <= RST_CLOCK_LEVEL;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
endmodule

// File: port_steer.sv
// output enable, direction and source decode for one 8-bit section
`timescale 1ns/1ns
module port_steer #(
  parameter int W = xcvr_pkg::SECTION_W
) (
  input wire logic rst,
  input wire logic output_enable_n,
  input wire logic port_drive_side,
  input wire logic a_port_source_select,
  input wire logic b_port_source_select,
  input wire logic [W-1:0] a_live,
  input wire logic [W-1:0] b_live,
  input wire logic [W-1:0] a_stored,
  input wire logic [W-1:0] b_stored,
  output logic [W-1:0] a_out,
  output logic [W-1:0] a_oe,
  output logic [W-1:0] b_out,
  output logic [W-1:0] b_oe,
  output logic a_driven,
  output logic b_driven
);
  import xcvr_pkg::*;

  drive_t mode;

  // ==========================================================
  // pure combinational decode, no capture edge needed
  always_comb begin
    mode = DRIVE_NONE;
    if (!rst && !output_enable_n) begin
      mode = port_drive_side ? DRIVE_B : DRIVE_A;
    end
  end

  // ==========================================================
  // only one side can ever be enabled, decode is one-hot by enum
  always_comb begin
    a_out = '0;
    b_out = '0;
    a_driven = 1'b0;
    b_driven = 1'b0;
    case (mode)
      DRIVE_A: begin
        a_driven = 1'b1;
        a_out = a_port_source_select ? b_stored : b_live;
      end
      DRIVE_B: begin
        b_driven = 1'b1;
        b_out = b_port_source_select ? a_stored : a_live;
      end
      DRIVE_NONE: begin
        a_driven = 1'b0;
      end
      default: begin
        b_driven = 1'b0;
      end
    endcase
  end

  // a_driven and b_driven are exclusive by construction
  assign a_oe = {W{a_driven}};
  assign b_oe = {W{b_driven}};
endmodule

// File: far_bus.sv
// far side logic bus model for one 16-bit port
`timescale 1ns/1ns
module far_bus (
  input wire logic [15:0] oe,
  input wire logic [15:0] drv,
  input wire logic [15:0] far,
  output logic [15:0] pin
);
  // ==========================================
  // wire resolution
  // far side lets go of every bit the block drives, so no contention
  assign pin = (oe & drv) | (~oe & far);
endmodule

// File: xcvr_properties.sv
// port assertions for the registered bus transceiver
`timescale 1ns/1ns
module xcvr_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] output_enable_n,
  input wire logic [1:0] port_drive_side,
  input wire logic [1:0] a_capture_clock,
  input wire logic [1:0] b_capture_clock,
  input wire logic [1:0] a_port_source_select,
  input wire logic [1:0] b_port_source_select,
  input wire logic [15:0] a_port_data_in,
  input wire logic [15:0] a_port_data_out,
  input wire logic [15:0] a_port_data_oe,
  input wire logic [15:0] b_port_data_in,
  input wire logic [15:0] b_port_data_out,
  input wire logic [15:0] b_port_data_oe
);
  // ==========================================
  // decode helpers
  wire [1:0] drv_a = ~output_enable_n & ~port_drive_side;
  wire [1:0] drv_b = ~output_enable_n & port_drive_side;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // drive path
  property p_one; (a_port_data_oe & b_port_data_oe) == 16'h0000; endproperty
  a_one: assert property (p_one) else $error("both driven");
  property p_off; output_enable_n[0] |->
    {a_port_data_oe[7:0], b_port_data_oe[7:0]} == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("drive when off");
  property p_lva; drv_a[0] && !a_port_source_select[0] |->
    a_port_data_oe[7:0] == 8'hFF && a_port_data_out[7:0] ==
    b_port_data_in[7:0]; endproperty
  a_lva: assert property (p_lva) else $error("live a bad");
  property p_lvb; drv_b[0] && !b_port_source_select[0] |->
    b_port_data_oe[7:0] == 8'hFF && b_port_data_out[7:0] ==
    a_port_data_in[7:0]; endproperty
  a_lvb: assert property (p_lvb) else $error("live b bad");
  property p_sec1; drv_b[1] |-> b_port_data_oe[15:8] == 8'hFF &&
    a_port_data_oe[15:8] == 8'h00; endproperty
  a_sec1: assert property (p_sec1) else $error("section 1 bad");
  // ==========================================
  // stored path: register loads at the edge that sees the rise
  property p_stb; b_capture_clock[0] && !$past(b_capture_clock[0]) &&
    !$past(rst) ##1 drv_a[0] && a_port_source_select[0] |->
    a_port_data_out[7:0] == $past(b_port_data_in[7:0]); endproperty
  a_stb: assert property (p_stb) else $error("stored b bad");
  property p_sta; a_capture_clock[1] && !$past(a_capture_clock[1]) &&
    !$past(rst) ##1 drv_b[1] && b_port_source_select[1] |->
    b_port_data_out[15:8] == $past(a_port_data_in[15:8]); endproperty
  a_sta: assert property (p_sta) else $error("stored a bad");
  // reset gates the enables, so this one must run during reset
  property p_rst; disable iff (1'b0) rst |->
    (a_port_data_oe | b_port_data_oe) == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("drive in reset");
endmodule
bind registered_bus_transceiver xcvr_properties u_props (.ref_clk, .rst,
  .output_enable_n, .port_drive_side, .a_capture_clock, .b_capture_clock,
  .a_port_source_select, .b_port_source_select, .a_port_data_in,
  .a_port_data_out, .a_port_data_oe, .b_port_data_in, .b_port_data_out,
  .b_port_data_oe);

// File: registered_bus_transceiver_tb.sv
// self-checking bench for the registered bus transceiver
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module registered_bus_transceiver_tb;
  import xcvr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] output_enable_n = 2'h3, port_drive_side = 2'h0;
  logic [1:0] a_capture_clock = 2'h0, b_capture_clock = 2'h0;
  logic [1:0] a_port_source_select = 2'h0, b_port_source_select = 2'h0;
  logic [15:0] a_far = 16'h0, b_far = 16'h0, sa = 16'h0, sb = 16'h0;
  logic [15:0] a_pin, b_pin, a_out, a_oe, b_out, b_oe;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, ex, seed = 32'hF430E7E9;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0;
  int mismatches = 0, total_checks = 0;
  logic [31:0] q[$];
  // ==========================================
  // clock, block and far side buses
  always #50 ref_clk = ~ref_clk;
  registered_bus_transceiver dut (.ref_clk, .rst, .output_enable_n,
    .port_drive_side, .a_capture_clock, .b_capture_clock,
    .a_port_source_select, .b_port_source_select, .a_port_data_in(a_pin),
    .a_port_data_out(a_out), .a_port_data_oe(a_oe), .b_port_data_in(b_pin),
    .b_port_data_out(b_out), .b_port_data_oe(b_oe), .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata);
  far_bus u_far_a (.oe(a_oe), .drv(a_out), .far(a_far), .pin(a_pin));
  far_bus u_far_b (.oe(b_oe), .drv(b_out), .far(b_far), .pin(b_pin));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // one register access; reads note their expected word
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    if (w) reg_write <= 1'b1;
    else reg_read <= 1'b1;
    if (!w) q.push_back(d);
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  endtask
  // compare both ports against the decode worked out here
  task automatic look();
    logic [15:0] oa, ob, ea, eb;
    @(negedge ref_clk);
    for (int s = 0; s < 2; s++) begin
      oa[s*8+:8] = {8{~output_enable_n[s] & ~port_drive_side[s]}};
      ob[s*8+:8] = {8{~output_enable_n[s] & port_drive_side[s]}};
      ea[s*8+:8] = a_port_source_select[s] ? sb[s*8+:8] : b_far[s*8+:8];
      eb[s*8+:8] = b_port_source_select[s] ? sa[s*8+:8] : a_far[s*8+:8];
    end
    `CHK(a_oe, oa)
    `CHK(b_oe, ob)
    `CHK(a_out & oa, ea & oa)
    `CHK(b_out & ob, eb & ob)
  endtask
  // capture only from ports the block leaves undriven, then look
  task automatic cap(input logic [1:0] oen, input logic s);
    @(posedge ref_clk);
    output_enable_n <= oen;
    port_drive_side <= {2{s}};
    a_port_source_select <= 2'h3;
    b_port_source_select <= 2'h3;
    {a_far, b_far} <= xs();
    a_capture_clock <= {2{oen[0] | s}};
    b_capture_clock <= {2{oen[0] | ~s}};
    @(posedge ref_clk);
    a_capture_clock <= 2'h0;
    b_capture_clock <= 2'h0;
    if (oen[0] | s) sa = a_far;
    if (oen[0] | ~s) sb = b_far;
    look();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // scoreboard: read word stands only in the cycle after the strobe
  always @(posedge ref_clk) rd_d <= reg_read;
  always @(negedge ref_clk) begin
    if (rd_d === 1'b1) begin
      ex = q.pop_front();
      `CHK(reg_rdata, ex)
    end
  end
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #500000;
    mismatches++;
    tally_and_finish();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    `CHK(a_oe | b_oe, 16'h0000)
    rst <= 1'b0;
    acc(1'b0, OFS_STORED_A, 32'h0);
    cap(2'h3, 1'b0);
    acc(1'b0, OFS_STORED_A, {16'h0, sa});
    acc(1'b0, OFS_STORED_B, {16'h0, sb});
    acc(1'b0, OFS_CAPTURE_FLAGS, 32'hF);
    acc(1'b1, OFS_CAPTURE_FLAGS, 32'hF);
    acc(1'b0, OFS_CAPTURE_FLAGS, 32'h0);
    acc(1'b0, 8'h10, 32'h0);
    cap(2'h0, 1'b0);
    cap(2'h0, 1'b1);
    acc(1'b0, OFS_STORED_B, {16'h0, sb});
    acc(1'b0, OFS_DRIVE_STATUS, 32'hC);
    // every control code on both sections, fresh bus data each time
    for (int i = 0; i < 256; i++) begin
      @(posedge ref_clk);
      {output_enable_n, port_drive_side} <= i[7:4];
      {a_port_source_select, b_port_source_select} <= i[3:0];
      {a_far, b_far} <= xs();
      look();
    end
    // a capture in the clearing cycle keeps its flag set
    fork
      acc(1'b1, OFS_CAPTURE_FLAGS, 32'hF);
      begin
        @(posedge ref_clk);
        a_capture_clock <= 2'h3;
      end
    join
    a_capture_clock <= 2'h0;
    acc(1'b0, OFS_CAPTURE_FLAGS, 32'h3);
    // mid-run reset with outputs enabled: ports off, storage cleared
    @(posedge ref_clk);
    rst <= 1'b1;
    output_enable_n <= 2'h0;
    @(negedge ref_clk);
    `CHK(a_oe | b_oe, 16'h0000)
    @(posedge ref_clk);
    rst <= 1'b0;
    sa = 16'h0;
    sb = 16'h0;
    acc(1'b0, OFS_STORED_B, 32'h0);
    acc(1'b0, OFS_CAPTURE_FLAGS, 32'h0);
    look();
    tally_and_finish();
  end
endmodule
